// ---- pkg/vppm_pkg.sv ----
// Purpose: shared constants for the voltage phase plausibility monitor
// Assumes: one 25 MHz clock; measured values arrive already on that clock
// Notes: setting defaults are listed here for whoever drives the setting ports

package vppm_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_TIME_S = 1;
  localparam int unsigned TICKS_PER_SEC = CLK_HZ * SEC_TIME_S;
  localparam int unsigned DELAY_W = 10;
  localparam logic [9:0] DELAY_MIN_S = 10'h001;
  localparam logic [9:0] DELAY_MAX_S = 10'h3e7;
  localparam logic [9:0] DELAY_DEF_S = 10'h01e;

  // ****************************************
  // wiring configuration codes
  // ****************************************
  localparam logic [1:0] WIRE_THREE_PHASE_FOUR_WIRE = 2'h0;
  localparam logic [1:0] WIRE_THREE_PHASE_THREE_WIRE = 2'h1;
  localparam logic [1:0] WIRE_SINGLE_PHASE_TWO_WIRE = 2'h2;

  // ****************************************
  // alarm classes
  // ****************************************
  localparam logic [2:0] CLASS_A = 3'h0;
  localparam logic [2:0] CLASS_B = 3'h1;
  localparam logic [2:0] CLASS_C = 3'h2;
  localparam logic [2:0] CLASS_D = 3'h3;
  localparam logic [2:0] CLASS_E = 3'h4;
  localparam logic [2:0] CLASS_F = 3'h5;
  localparam logic [2:0] CLASS_CONTROL = 3'h6;
  localparam logic [2:0] CLASS_NONE = 3'h7;

  // ****************************************
  // setting defaults
  // ****************************************
  localparam logic ROT_ENABLE_DEF = 1'b1;
  localparam logic ROT_SELF_ACK_DEF = 1'b1;
  localparam logic PLAUS_ENABLE_DEF = 1'b0;
  localparam logic PLAUS_SELF_ACK_DEF = 1'b0;
  localparam logic LOCKABLE_DEF = 1'b0;
  localparam logic [2:0] CLASS_DEF = CLASS_B;

  // ****************************************
  // plausibility angle window and display
  // ****************************************
  localparam logic signed [8:0] ANGLE_LIM_DEG = 9'sh00a;
  localparam logic [1:0] DISP_NONE = 2'h0;
  localparam logic [1:0] DISP_ROT_MISMATCH = 2'h1;
  localparam logic [1:0] DISP_VOLT_MISMATCH = 2'h2;

  // ****************************************
  // plausibility delay states
  // ****************************************
  typedef enum logic [2:0] {
    VPPM_IDLE = 3'h1,
    VPPM_TIMING = 3'h2,
    VPPM_EXPIRED = 3'h4
  } vppm_dly_state_t;

endpackage

// ---- pkg/vppm_alarm_if.sv ----
// Purpose: carrier between a check and its alarm latch
// Assumes: single clock domain
// Notes: fault is the qualified condition, ack a one-cycle pulse

`timescale 1ns/1ps

interface vppm_alarm_if;
  logic fault;
  logic enable;
  logic self_ack;
  logic ack;
  logic [2:0] class_sel;
  logic alarm;
  logic [2:0] alarm_class;

  modport check (output fault, output enable, output self_ack, output ack,
                 output class_sel, input alarm, input alarm_class);
  modport latch (input fault, input enable, input self_ack, input ack,
                 input class_sel, output alarm, output alarm_class);
endinterface

// ---- rtl/vppm_alarm_latch.sv ----
// Purpose: alarm flag with self or manual acknowledge
// Assumes: fault and ack on clk_in
// Notes: a fault present in the ack cycle keeps the alarm set

`timescale 1ns/1ps

module vppm_alarm_latch (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // check side
  vppm_alarm_if.latch al
);

  // ****************************************
  // alarm flag
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      al.alarm <= 1'b0;
    end else if (!al.enable) begin
      al.alarm <= 1'b0;
    end else if (al.fault) begin
      al.alarm <= 1'b1;
    end else if (al.self_ack) begin
      al.alarm <= 1'b0;
    end else if (al.ack) begin
      al.alarm <= 1'b0;
    end
  end

  // class held from the moment of tripping, so a later setting change
  // does not alter the action of an alarm already standing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      al.alarm_class <= vppm_pkg::CLASS_NONE;
    end else if (al.enable && al.fault && !al.alarm) begin
      al.alarm_class <= al.class_sel;
    end else if (!al.enable || (!al.fault && (al.self_ack || al.ack))) begin
      // dropped on the same edge that clears the alarm
      al.alarm_class <= vppm_pkg::CLASS_NONE;
    end
  end

endmodule

// ---- rtl/vppm_monitor.sv ----
// Purpose: phase rotation and voltage plausibility alarm logic
// Assumes: measured values and status flags come from logic on clk_in;
//   breaker feedbacks and acknowledge inputs are pins
// Notes: settings are plain ports, see package for their defaults
// Notes on behaviour
// - rotation differs between systems: raise rotation alarm, inhibit synchronizing
// - rotation alarm never blocks a dead busbar closure
// - rotation trip sets rotation alarm flag and rotation mismatch display
// - three-phase wiring on both: check only above half rated voltage
// - single-phase wiring on both: rotation taken from setting, not measured
// - rotation enable on/off, default on; off raises no alarm
// - each check has class A to F or Control, default B
// - self-acknowledge clears alarm when fault gone; rotation default set
// - without self-acknowledge alarm latches until manual or external ack
// - lockable set: check runs only while lock status false
// - plausibility runs only while breakers connect both systems
// - plausibility fault when status flags disagree
// - both okay: fault also when angle outside plus or minus ten degrees
// - plausibility alarm after fault held for delay of 1 to 999 s
// - plausibility trip sets voltage mismatch flag and display; a standing rotation alarm keeps display on rotation mismatch
// - plausibility enable on/off, default off; off raises no alarm

`timescale 1ns/1ps

module vppm_monitor #(
  parameter int unsigned TICKS_PER_SEC = vppm_pkg::TICKS_PER_SEC,
  parameter int unsigned DELAY_W = vppm_pkg::DELAY_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // discrete pins
  input wire logic cba_closed_in,
  input wire logic cbb_closed_in,
  input wire logic manual_ack_in,
  input wire logic ext_ack_in,
  // measurement results
  input wire logic [1:0] wiring_a_in,
  input wire logic [1:0] wiring_b_in,
  input wire logic [15:0] volt_a_in,
  input wire logic [15:0] volt_b_in,
  input wire logic [15:0] rated_volt_in,
  input wire logic rot_a_cw_in,
  input wire logic rot_b_cw_in,
  input wire logic single_rot_cw_in,
  input wire logic status_a_ok_in,
  input wire logic status_b_ok_in,
  input wire logic signed [8:0] phase_angle_in,
  input wire logic lock_monitoring_in,
  // rotation check settings
  input wire logic rot_enable_in,
  input wire logic [2:0] rot_class_in,
  input wire logic rot_self_ack_in,
  input wire logic rot_lockable_in,
  // plausibility check settings
  input wire logic plaus_enable_in,
  input wire logic [DELAY_W-1:0] plaus_delay_s_in,
  input wire logic [2:0] plaus_class_in,
  input wire logic plaus_self_ack_in,
  input wire logic plaus_lockable_in,
  // closure requests
  input wire logic sync_close_req_in,
  input wire logic dead_bus_req_in,
  // alarms
  output logic rot_alarm_out,
  output logic [2:0] rot_class_out,
  output logic plaus_alarm_out,
  output logic [2:0] plaus_class_out,
  output logic plaus_timing_out,
  output logic [1:0] display_out,
  // closure permits
  output logic sync_close_permit_out,
  output logic dead_bus_permit_out
);

  // ****************************************
  // parameter checks
  // ****************************************
  generate
    if (TICKS_PER_SEC < 2) begin : g_bad_ticks
      $error("TICKS_PER_SEC must be at least 2");
    end
    if (DELAY_W != 10) begin : g_bad_width
      $error("DELAY_W must be 10 to hold 999 s");
    end
  endgenerate

  localparam int unsigned PRE_W = $clog2(TICKS_PER_SEC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS_PER_SEC - 1);

  function automatic logic is_three_phase(input logic [1:0] w);
    is_three_phase = (w == vppm_pkg::WIRE_THREE_PHASE_FOUR_WIRE) ||
                     (w == vppm_pkg::WIRE_THREE_PHASE_THREE_WIRE);
  endfunction

  // strictly above half rated: twice the voltage beats rated
  function automatic logic above_half(input logic [15:0] v, input logic [15:0] r);
    above_half = {v, 1'b0} > {1'b0, r};
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [1:0] ack_prev_ff;
  logic cba_closed;
  logic cbb_closed;
  logic ack_pulse;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {cba_closed_in, cbb_closed_in, manual_ack_in, ext_ack_in};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_prev_ff <= 2'h0;
    end else begin
      ack_prev_ff <= sync2_ff[1:0];
    end
  end

  assign cba_closed = sync2_ff[3];
  assign cbb_closed = sync2_ff[2];
  // a held button acknowledges once, on its rising edge
  assign ack_pulse = |(sync2_ff[1:0] & ~ack_prev_ff);

  // ****************************************
  // phase rotation check
  // ****************************************
  logic three_both;
  logic single_both;
  logic volt_live;
  logic rot_a_eff;
  logic rot_b_eff;
  logic rot_run;
  logic rot_fault;

  assign three_both = is_three_phase(wiring_a_in) && is_three_phase(wiring_b_in);
  assign single_both = (wiring_a_in == vppm_pkg::WIRE_SINGLE_PHASE_TWO_WIRE) &&
                       (wiring_b_in == vppm_pkg::WIRE_SINGLE_PHASE_TWO_WIRE);
  assign volt_live = above_half(volt_a_in, rated_volt_in) &&
                     above_half(volt_b_in, rated_volt_in);
  assign rot_a_eff = single_both ? single_rot_cw_in : rot_a_cw_in;
  assign rot_b_eff = single_both ? single_rot_cw_in : rot_b_cw_in;
  assign rot_run = rot_enable_in && !(rot_lockable_in && lock_monitoring_in) &&
                   ((three_both && volt_live) || single_both);
  assign rot_fault = rot_run && (rot_a_eff != rot_b_eff);

  vppm_alarm_if rot_if ();

  assign rot_if.fault = rot_fault;
  assign rot_if.enable = rot_enable_in;
  assign rot_if.self_ack = rot_self_ack_in;
  assign rot_if.ack = ack_pulse;
  assign rot_if.class_sel = rot_class_in;

  vppm_alarm_latch u_rot_latch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .al(rot_if.latch)
  );

  // ****************************************
  // voltage plausibility condition
  // ****************************************
  logic connected;
  logic angle_out;
  logic plaus_cond;
  logic plaus_hold;

  assign connected = cba_closed && cbb_closed;
  assign angle_out = (phase_angle_in > vppm_pkg::ANGLE_LIM_DEG) ||
                     (phase_angle_in < -vppm_pkg::ANGLE_LIM_DEG);
  assign plaus_cond = connected && ((status_a_ok_in != status_b_ok_in) ||
                      (status_a_ok_in && status_b_ok_in && angle_out));
  assign plaus_hold = plaus_enable_in && !(plaus_lockable_in && lock_monitoring_in) &&
                      plaus_cond;

  // ****************************************
  // plausibility delay
  // ****************************************
  logic [DELAY_W-1:0] delay_eff;
  vppm_pkg::vppm_dly_state_t state_ff;
  vppm_pkg::vppm_dly_state_t nxt_state;
  logic [PRE_W-1:0] pre_ff;
  logic [DELAY_W-1:0] sec_ff;
  logic sec_tick;
  logic delay_done;

  // out-of-range settings are pinned to the nearest legal delay
  always_comb begin
    if (plaus_delay_s_in < vppm_pkg::DELAY_MIN_S) begin
      delay_eff = vppm_pkg::DELAY_MIN_S;
    end else if (plaus_delay_s_in > vppm_pkg::DELAY_MAX_S) begin
      delay_eff = vppm_pkg::DELAY_MAX_S;
    end else begin
      delay_eff = plaus_delay_s_in;
    end
  end

  assign sec_tick = (state_ff == vppm_pkg::VPPM_TIMING) && (pre_ff == PRE_LAST);
  assign delay_done = sec_tick && ((sec_ff + 10'h001) >= delay_eff);

  always_comb begin
    case (state_ff)
      vppm_pkg::VPPM_IDLE: begin
        nxt_state = plaus_hold ? vppm_pkg::VPPM_TIMING : vppm_pkg::VPPM_IDLE;
      end
      vppm_pkg::VPPM_TIMING: begin
        if (!plaus_hold) begin
          nxt_state = vppm_pkg::VPPM_IDLE;
        end else if (delay_done) begin
          nxt_state = vppm_pkg::VPPM_EXPIRED;
        end else begin
          nxt_state = vppm_pkg::VPPM_TIMING;
        end
      end
      vppm_pkg::VPPM_EXPIRED: begin
        nxt_state = plaus_hold ? vppm_pkg::VPPM_EXPIRED : vppm_pkg::VPPM_IDLE;
      end
      default: begin
        nxt_state = vppm_pkg::VPPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= vppm_pkg::VPPM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // prescaler and seconds restart from zero outside timing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_ff <= '0;
      sec_ff <= '0;
    end else if (state_ff != vppm_pkg::VPPM_TIMING || !plaus_hold) begin
      pre_ff <= '0;
      sec_ff <= '0;
    end else if (sec_tick) begin
      pre_ff <= '0;
      sec_ff <= sec_ff + 10'h001;
    end else begin
      pre_ff <= pre_ff + PRE_W'(1);
    end
  end

  vppm_alarm_if plaus_if ();

  assign plaus_if.fault = (state_ff == vppm_pkg::VPPM_EXPIRED) && plaus_hold;
  assign plaus_if.enable = plaus_enable_in;
  assign plaus_if.self_ack = plaus_self_ack_in;
  assign plaus_if.ack = ack_pulse;
  assign plaus_if.class_sel = plaus_class_in;

  vppm_alarm_latch u_plaus_latch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .al(plaus_if.latch)
  );

  // ****************************************
  // indication
  // ****************************************
  logic [1:0] disp_ff;

  // rotation shown first: it is the one that blocks synchronizing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      disp_ff <= vppm_pkg::DISP_NONE;
    end else if (rot_if.alarm) begin
      disp_ff <= vppm_pkg::DISP_ROT_MISMATCH;
    end else if (plaus_if.alarm) begin
      disp_ff <= vppm_pkg::DISP_VOLT_MISMATCH;
    end else begin
      disp_ff <= vppm_pkg::DISP_NONE;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rot_alarm_out = rot_if.alarm;
  assign rot_class_out = rot_if.alarm_class;
  assign plaus_alarm_out = plaus_if.alarm;
  assign plaus_class_out = plaus_if.alarm_class;
  assign plaus_timing_out = (state_ff == vppm_pkg::VPPM_TIMING);
  assign display_out = disp_ff;
  assign sync_close_permit_out = sync_close_req_in && !rot_if.alarm;
  assign dead_bus_permit_out = dead_bus_req_in;

endmodule

// ---- testbench/vppm_monitor_props.sv ----
// Purpose: port-level checks for the phase and plausibility monitor
// Assumes: one clock, reset active high
// Notes: plausibility hold is not rebuilt here, breakers pass a synchroniser

`timescale 1ns/1ps

module vppm_monitor_props #(
  parameter int unsigned TICKS_PER_SEC = 10,
  parameter int unsigned DELAY_W = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // inputs
  input wire logic manual_ack_in,
  input wire logic ext_ack_in,
  input wire logic [1:0] wiring_a_in,
  input wire logic [1:0] wiring_b_in,
  input wire logic [15:0] volt_a_in,
  input wire logic [15:0] volt_b_in,
  input wire logic [15:0] rated_volt_in,
  input wire logic rot_a_cw_in,
  input wire logic rot_b_cw_in,
  input wire logic lock_monitoring_in,
  input wire logic rot_enable_in,
  input wire logic [2:0] rot_class_in,
  input wire logic rot_self_ack_in,
  input wire logic rot_lockable_in,
  input wire logic plaus_enable_in,
  input wire logic [DELAY_W-1:0] plaus_delay_s_in,
  input wire logic sync_close_req_in,
  input wire logic dead_bus_req_in,
  // outputs watched
  input wire logic rot_alarm_out,
  input wire logic [2:0] rot_class_out,
  input wire logic plaus_alarm_out,
  input wire logic [2:0] plaus_class_out,
  input wire logic plaus_timing_out,
  input wire logic [1:0] display_out,
  input wire logic sync_close_permit_out,
  input wire logic dead_bus_permit_out
);
  logic rot_fault;
  int unsigned dly_eff;
  logic [31:0] run_ff;
  logic [31:0] last_run_ff;
  logic [2:0] quiet_ff;

  // ****************************************
  // helper logic
  // ****************************************
  assign rot_fault = rot_enable_in && !(rot_lockable_in && lock_monitoring_in) && wiring_a_in < 2'h2
    && wiring_b_in < 2'h2 && {volt_a_in, 1'b0} > {1'b0, rated_volt_in}
    && {volt_b_in, 1'b0} > {1'b0, rated_volt_in} && rot_a_cw_in != rot_b_cw_in;
  assign dly_eff = plaus_delay_s_in == 0 ? 1 : (plaus_delay_s_in > 999 ? 999 : int'(plaus_delay_s_in));

  // length of the last uninterrupted timing run
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_ff <= 32'h0;
      last_run_ff <= 32'h0;
    end else if (plaus_timing_out) begin
      run_ff <= run_ff + 32'h1;
    end else begin
      run_ff <= 32'h0;
      if (run_ff != 32'h0) begin
        last_run_ff <= run_ff;
      end
    end
  end

  // ack pins quiet long enough that no pulse can be in flight
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      quiet_ff <= 3'h0;
    end else if (manual_ack_in || ext_ack_in) begin
      quiet_ff <= 3'h0;
    end else if (quiet_ff != 3'h7) begin
      quiet_ff <= quiet_ff + 3'h1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence rot_trip_s;
    $rose(rot_alarm_out);
  endsequence
  sequence plaus_trip_s;
    $rose(plaus_alarm_out) && !rot_alarm_out;
  endsequence

  sync_block_a: assert property (sync_close_permit_out == (sync_close_req_in && !rot_alarm_out))
    else $error("sync permit wrong");
  dead_bus_a: assert property (dead_bus_permit_out == dead_bus_req_in)
    else $error("dead bus permit blocked");
  rot_raise_a: assert property (rot_fault |=> rot_alarm_out)
    else $error("rotation alarm missing");
  rot_clear_a: assert property (rot_self_ack_in && !rot_fault |=> !rot_alarm_out)
    else $error("rotation alarm not self cleared");
  rot_off_a: assert property (!rot_enable_in |=> !rot_alarm_out)
    else $error("rotation alarm while disabled");
  rot_latch_a: assert property (rot_alarm_out && !rot_self_ack_in && rot_enable_in && quiet_ff > 3'h4 |=> rot_alarm_out)
    else $error("rotation alarm dropped unacknowledged");
  rot_disp_a: assert property (rot_trip_s |=> display_out == vppm_pkg::DISP_ROT_MISMATCH)
    else $error("rotation display missing");
  class_cap_a: assert property (rot_trip_s |-> rot_class_out == $past(rot_class_in))
    else $error("rotation class not captured");
  class_none_a: assert property (!plaus_alarm_out |-> plaus_class_out == vppm_pkg::CLASS_NONE)
    else $error("class shown without alarm");
  plaus_disp_a: assert property (plaus_trip_s |=> display_out == vppm_pkg::DISP_VOLT_MISMATCH)
    else $error("voltage display missing");
  plaus_delay_a: assert property ($rose(plaus_alarm_out) |-> last_run_ff == dly_eff * TICKS_PER_SEC)
    else $error("plausibility delay wrong");
  plaus_off_a: assert property (!plaus_enable_in |=> !plaus_alarm_out)
    else $error("plausibility alarm while disabled");
endmodule

bind vppm_monitor vppm_monitor_props #(.TICKS_PER_SEC(TICKS_PER_SEC), .DELAY_W(DELAY_W)) props (.*);

// ---- testbench/vppm_front_end.sv ----
// Purpose: measurement front end and breaker feedback model
// Assumes: tasks called just after a rising edge
// Notes: feedbacks are clean levels, no bounce

`timescale 1ns/1ps

module vppm_front_end (
  // feedbacks
  output logic cba_closed_out,
  output logic cbb_closed_out,
  // measurements
  output logic [1:0] wiring_a_out,
  output logic [1:0] wiring_b_out,
  output logic [15:0] volt_a_out,
  output logic [15:0] volt_b_out,
  output logic [15:0] rated_volt_out,
  output logic rot_a_cw_out,
  output logic rot_b_cw_out,
  output logic single_rot_cw_out,
  output logic status_a_ok_out,
  output logic status_b_ok_out,
  output logic signed [8:0] phase_angle_out
);
  assign rated_volt_out = 16'h0190;
  assign single_rot_cw_out = 1'b1;

  task automatic sys(input logic [1:0] w, input logic [15:0] v, input logic ra, input logic rb);
    wiring_a_out <= w;
    wiring_b_out <= w;
    volt_a_out <= v;
    volt_b_out <= v;
    rot_a_cw_out <= ra;
    rot_b_cw_out <= rb;
  endtask

  task automatic tie(input logic ca, input logic cb, input logic oka, input logic okb, input logic signed [8:0] a);
    cba_closed_out <= ca;
    cbb_closed_out <= cb;
    status_a_ok_out <= oka;
    status_b_ok_out <= okb;
    phase_angle_out <= a;
  endtask

  initial begin
    sys(2'h0, 16'h012c, 1'b1, 1'b1);
    tie(1'b0, 1'b0, 1'b1, 1'b1, 9'sh000);
  end
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the phase and plausibility monitor
// Assumes: one second shortened to ten clocks
// Notes: expectations queued by the driver, compared by the watcher

`timescale 1ns/1ps

module tb_top;
  localparam int TPS = 10;
  localparam logic [2:0] NC = vppm_pkg::CLASS_NONE;
  localparam logic [2:0] CE = vppm_pkg::CLASS_E;
  localparam logic [1:0] DR = vppm_pkg::DISP_ROT_MISMATCH;
  localparam logic [1:0] DV = vppm_pkg::DISP_VOLT_MISMATCH;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic manual_ack_in = 1'b0;
  logic ext_ack_in = 1'b0;
  logic lock_monitoring_in = 1'b0;
  logic rot_enable_in = vppm_pkg::ROT_ENABLE_DEF;
  logic [2:0] rot_class_in = vppm_pkg::CLASS_DEF;
  logic rot_self_ack_in = vppm_pkg::ROT_SELF_ACK_DEF;
  logic rot_lockable_in = vppm_pkg::LOCKABLE_DEF;
  logic plaus_enable_in = vppm_pkg::PLAUS_ENABLE_DEF;
  logic [9:0] plaus_delay_s_in = 10'h001;
  logic [2:0] plaus_class_in = vppm_pkg::CLASS_DEF;
  logic plaus_self_ack_in = vppm_pkg::PLAUS_SELF_ACK_DEF;
  logic plaus_lockable_in = vppm_pkg::LOCKABLE_DEF;
  logic sync_close_req_in = 1'b1;
  logic dead_bus_req_in = 1'b0;
  logic cba_closed_in, cbb_closed_in, rot_a_cw_in, rot_b_cw_in, single_rot_cw_in, status_a_ok_in, status_b_ok_in;
  logic [1:0] wiring_a_in, wiring_b_in, display_out;
  logic [15:0] volt_a_in, volt_b_in, rated_volt_in;
  logic signed [8:0] phase_angle_in;
  logic rot_alarm_out, plaus_alarm_out, plaus_timing_out, sync_close_permit_out, dead_bus_permit_out;
  logic [2:0] rot_class_out, plaus_class_out;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h3976d16b;
  int d;
  int r;
  logic [12:0] notes[$];
  event seen;

  vppm_monitor #(.TICKS_PER_SEC(TPS)) dut (.*);
  vppm_front_end fe (.cba_closed_out(cba_closed_in), .cbb_closed_out(cbb_closed_in),
    .wiring_a_out(wiring_a_in), .wiring_b_out(wiring_b_in), .volt_a_out(volt_a_in), .volt_b_out(volt_b_in),
    .rated_volt_out(rated_volt_in), .rot_a_cw_out(rot_a_cw_in), .rot_b_cw_out(rot_b_cw_in),
    .single_rot_cw_out(single_rot_cw_in), .status_a_ok_out(status_a_ok_in), .status_b_ok_out(status_b_ok_in),
    .phase_angle_out(phase_angle_in));

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) {sync_close_req_in, dead_bus_req_in} <= 2'($random(seed));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic note(input logic ra, input logic pa, input logic [1:0] dsp, input logic [2:0] rc,
                      input logic [2:0] pc, input logic tm = 1'b0);
    @(negedge clk_in);
    notes.push_back({ra, pa, dsp, sync_close_req_in && !ra, rc, pc, tm, dead_bus_req_in});
    -> seen;
    @(posedge clk_in);
  endtask

  task automatic ack(input logic ext);
    if (ext) ext_ack_in <= 1'b1;
    else manual_ack_in <= 1'b1;
    cyc(2);
    manual_ack_in <= 1'b0;
    ext_ack_in <= 1'b0;
    cyc(6);
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // results are only judged against the oldest queued note
  always @(seen) check({rot_alarm_out, plaus_alarm_out, display_out, sync_close_permit_out,
    rot_class_out, plaus_class_out, plaus_timing_out, dead_bus_permit_out}, notes.pop_front());

  initial begin
    cyc(30000);
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cyc(2);
    rst_in <= 1'b0;
    cyc(3);
    for (int c = 0; c < 7; c++) begin
      rot_class_in <= 3'(c);
      fe.sys(2'(c % 2), 16'h012c, 1'b1, 1'b0);
      cyc(4);
      note(1'b1, 1'b0, DR, 3'(c), NC);
      fe.sys(2'(c % 2), 16'h012c, 1'b0, 1'b0);
      cyc(3);
      note(1'b0, 1'b0, 2'h0, NC, NC);
    end
    // exactly half rated, single phase, disabled, locked: all quiet
    for (int k = 0; k < 4; k++) begin
      rot_enable_in <= (k != 2);
      rot_lockable_in <= (k == 3);
      lock_monitoring_in <= (k == 3);
      fe.sys(k == 1 ? vppm_pkg::WIRE_SINGLE_PHASE_TWO_WIRE : 2'h1, k == 0 ? 16'h00c8 : 16'h012c, 1'b1, 1'b0);
      cyc(4);
      note(1'b0, 1'b0, 2'h0, NC, NC);
    end
    lock_monitoring_in <= 1'b0;
    cyc(4);
    note(1'b1, 1'b0, DR, 3'h6, NC);
    fe.sys(2'h0, 16'h012c, 1'b0, 1'b0);
    cyc(3);
    rot_lockable_in <= 1'b0;
    rot_self_ack_in <= 1'b0;
    rot_class_in <= vppm_pkg::CLASS_B;
    for (int k = 0; k < 2; k++) begin
      fe.sys(2'h0, 16'h012c, 1'b0, 1'b1);
      cyc(4);
      fe.sys(2'h0, 16'h012c, 1'b1, 1'b1);
      cyc(8);
      note(1'b1, 1'b0, DR, vppm_pkg::CLASS_B, NC);
      ack(k == 1);
      note(1'b0, 1'b0, 2'h0, NC, NC);
    end
    // plausibility, rotation healthy from here on
    d = 1 + int'($unsigned($random(seed)) % 3);
    plaus_delay_s_in <= 10'(d);
    plaus_class_in <= CE;
    fe.tie(1'b1, 1'b1, 1'b1, 1'b0, 9'sh000);
    cyc(d * TPS + 8);
    note(1'b0, 1'b0, 2'h0, NC, NC);
    plaus_enable_in <= 1'b1;
    fe.tie(1'b1, 1'b0, 1'b1, 1'b0, 9'sh000);
    cyc(d * TPS + 8);
    note(1'b0, 1'b0, 2'h0, NC, NC);
    plaus_lockable_in <= 1'b1;
    lock_monitoring_in <= 1'b1;
    fe.tie(1'b1, 1'b1, 1'b1, 1'b0, 9'sh000);
    cyc(d * TPS + 8);
    note(1'b0, 1'b0, 2'h0, NC, NC);
    lock_monitoring_in <= 1'b0;
    fe.tie(1'b1, 1'b1, 1'b1, 1'b1, 9'sh000);
    cyc(4);
    for (int k = 0; k < 2; k++) begin
      fe.tie(1'b1, 1'b1, 1'b1, 1'b0, 9'sh000);
      cyc(d * TPS - 1);
      fe.tie(1'b1, 1'b1, 1'b1, 1'b1, 9'sh000);
      cyc(1);
    end
    note(1'b0, 1'b0, 2'h0, NC, NC);
    fe.tie(1'b1, 1'b1, 1'b0, 1'b1, 9'sh000);
    cyc(4);
    note(1'b0, 1'b0, 2'h0, NC, NC, 1'b1);
    cyc(d * TPS);
    note(1'b0, 1'b1, DV, NC, CE);
    fe.tie(1'b1, 1'b1, 1'b1, 1'b1, 9'sh00a);
    cyc(6);
    note(1'b0, 1'b1, DV, NC, CE);
    ack(1'b0);
    note(1'b0, 1'b0, 2'h0, NC, NC);
    plaus_self_ack_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = int'($unsigned($random(seed)) % 160);
      fe.tie(1'b1, 1'b1, 1'b1, 1'b1, 9'(k == 0 ? 11 : k == 1 ? -11 - r : k == 2 ? -10 : r % 21 - 10));
      cyc(d * TPS + 5);
      note(1'b0, k < 2, k < 2 ? DV : 2'h0, NC, k < 2 ? CE : NC);
      fe.tie(1'b1, 1'b1, 1'b1, 1'b1, 9'sh000);
      cyc(4);
      note(1'b0, 1'b0, 2'h0, NC, NC);
    end
    cyc(2);
    wrap_up();
  end
endmodule
